// >>> inc/timer16_pkg.sv
package timer16_pkg;
	localparam int          CNT_W       = 16;
	localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [15:0] CNT_RESET   = 16'h0000;
	localparam logic [15:0] CMP_RESET   = 16'h0000;
	localparam logic [3:0]  WAVE_NORMAL = 4'h0;
	localparam logic [3:0]  WAVE_PC8    = 4'h1;
	localparam logic [3:0]  WAVE_PC9    = 4'h2;
	localparam logic [3:0]  WAVE_PC10   = 4'h3;
	localparam logic [3:0]  WAVE_CLR_A  = 4'h4;
	localparam logic [3:0]  WAVE_PFC_I  = 4'h8;
	localparam logic [3:0]  WAVE_PFC_A  = 4'h9;
	localparam logic [3:0]  WAVE_PC_I   = 4'hA;
	localparam logic [3:0]  WAVE_PC_A   = 4'hB;
	localparam logic [3:0]  WAVE_CLR_I  = 4'hC;
	localparam logic [1:0]  ACT_NONE    = 2'h0;
	localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
	localparam logic [1:0]  ACT_CLEAR   = 2'h2;
	localparam logic [1:0]  ACT_SET     = 2'h3;

	typedef struct packed {
		logic [15:0] value;
		logic [1:0]  action;
		logic        force_strobe;
	} channel_cfg_t;

	typedef struct packed {
		logic [3:0]  sync;
		logic        down;
		logic [15:0] count;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [1:0]  act_a;
		logic [1:0]  act_b;
		logic        pin_a;
		logic        pin_b;
		logic        ovf;
		logic        flag_a;
		logic        flag_b;
		logic        match_a;
		logic        match_b;
	} timer_state_t;
endpackage

// >>> src/timer16.sv
`timescale 1ns/100ps
// Operation
// - action zero leaves the compare pin untouched at a match.
// - new action setting applies from the first match after the write.
// - force strobe applies the action at once in non-pwm modes.
// - waveform select sets counting; action only drives pins.
// - non-pwm: set, clear, toggle; pwm: inverted or non-inverted.
// - normal mode counts up and is never cleared by a match.
// - normal mode wraps 0xffff to 0x0000.
// - overflow flag set in the tick the counter wraps to zero in normal mode, or turns at bottom in pwm modes; never in clear-on-match modes.
// - counting only sets overflow; service acknowledge clears it.
// - counter write accepted at any time in normal mode.
// - clear-on-match mode clears at compare a (4) or capture (12).
// - phase-correct bottom holds low, top holds high, inverted opposite.
// - mode 9 with channel a action 1 toggles pin a, 50% duty.
// - synchronous apart from the asynchronous active-low reset; the tick is a clock enable.
// - double-buffered modes load compare from buffer at update point.
module timer16 (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        timer_tick,
	input  wire logic [3:0]                  waveform_select,
	input  wire timer16_pkg::channel_cfg_t   chan_a_cfg,
	input  wire timer16_pkg::channel_cfg_t   chan_b_cfg,
	input  wire logic [15:0]                 capture_value,
	input  wire logic                        counter_write,
	input  wire logic [15:0]                 counter_wdata,
	input  wire logic                        overflow_ack,
	input  wire logic                        flag_a_ack,
	input  wire logic                        flag_b_ack,
	output logic [15:0]                      counter_value,
	output logic                             overflow_flag,
	output logic                             compare_flag_a,
	output logic                             compare_flag_b,
	output logic                             channel_a_output_pin,
	output logic                             compare_output_pin_b
);
	timer16_pkg::timer_state_t s_reg;
	timer16_pkg::timer_state_t s_next;
	logic [15:0] top;
	logic        pwm;
	logic        buffered;
	logic        upd_bottom;
	logic        tick;
	logic        ovf_set;

	// pin action in non-pwm modes; zero means hold
	function automatic logic act_pin(input logic [1:0] act, input logic cur);
		case (act)
			timer16_pkg::ACT_TOGGLE: act_pin = ~cur;
			timer16_pkg::ACT_CLEAR:  act_pin = 1'b0;
			timer16_pkg::ACT_SET:    act_pin = 1'b1;
			default:                 act_pin = cur;
		endcase
	endfunction

	// phase-correct pwm level; up-match clears, down-match sets when non-inverted
	function automatic logic pwm_pin(input logic [1:0] act, input logic cur,
			input logic down, input logic [15:0] cmp, input logic [15:0] tp);
		logic lvl;
		lvl = down;
		if (cmp == timer16_pkg::CNT_BOTTOM)
			lvl = 1'b0;
		else if (cmp == tp)
			lvl = 1'b1;
		case (act)
			timer16_pkg::ACT_CLEAR: pwm_pin = lvl;
			timer16_pkg::ACT_SET:   pwm_pin = ~lvl;
			default:                pwm_pin = cur;
		endcase
	endfunction

	// mode decode; action never enters here, so counting ignores it
	always_comb begin
		pwm        = 1'b1;
		buffered   = 1'b1;
		upd_bottom = 1'b0;
		case (waveform_select)
			timer16_pkg::WAVE_PC8:   top = 16'h00FF;
			timer16_pkg::WAVE_PC9:   top = 16'h01FF;
			timer16_pkg::WAVE_PC10:  top = 16'h03FF;
			timer16_pkg::WAVE_PFC_I: begin
				top = capture_value;
				upd_bottom = 1'b1;
			end
			timer16_pkg::WAVE_PFC_A: begin
				top = s_reg.cmp_a;
				upd_bottom = 1'b1;
			end
			timer16_pkg::WAVE_PC_I:  top = capture_value;
			timer16_pkg::WAVE_PC_A:  top = s_reg.cmp_a;
			timer16_pkg::WAVE_CLR_A: begin
				top = s_reg.cmp_a;
				pwm = 1'b0;
				buffered = 1'b0;
			end
			timer16_pkg::WAVE_CLR_I: begin
				top = capture_value;
				pwm = 1'b0;
				buffered = 1'b0;
			end
			default: begin
				top = timer16_pkg::CNT_MAX;
				pwm = 1'b0;
				buffered = 1'b0;
			end
		endcase
	end

	// tick pin is a clock enable sync[3] holds the filtered level, so a
	// long high pin gives one tick only, where a bare stage edge could count twice
	assign tick = s_reg.sync[2] & s_reg.sync[1] & ~s_reg.sync[3];

	always_comb begin
		s_next      = s_reg;
		ovf_set     = 1'b0;
		// three-stage chain; the level moves only once stages two and three agree
		s_next.sync[2:0] = {s_reg.sync[1:0], timer_tick};
		if (s_reg.sync[2] == s_reg.sync[1])
			s_next.sync[3] = s_reg.sync[2];
		// flag raised on the tick that finds the counter equal to compare
		if (tick && s_reg.count == s_reg.cmp_a)
			s_next.flag_a = 1'b1;
		else if (flag_a_ack)
			s_next.flag_a = 1'b0;
		if (tick && s_reg.count == s_reg.cmp_b)
			s_next.flag_b = 1'b1;
		else if (flag_b_ack)
			s_next.flag_b = 1'b0;
		if (tick) begin
			s_next.match_a = (s_reg.count == s_reg.cmp_a);
			s_next.match_b = (s_reg.count == s_reg.cmp_b);
			// counter sequence
			if (!pwm) begin
				if (s_reg.count == top && waveform_select != timer16_pkg::WAVE_NORMAL)
					s_next.count = timer16_pkg::CNT_BOTTOM;
				else
					s_next.count = s_reg.count + 16'h0001;
				if (s_next.count == timer16_pkg::CNT_BOTTOM
						&& waveform_select == timer16_pkg::WAVE_NORMAL) begin
					s_next.ovf = 1'b1;
					ovf_set    = 1'b1;
				end
			end else begin
				if (!s_reg.down && s_reg.count >= top) begin
					s_next.down  = 1'b1;
					s_next.count = top - 16'h0001;
				end else if (s_reg.down && s_reg.count == timer16_pkg::CNT_BOTTOM) begin
					s_next.down  = 1'b0;
					s_next.count = 16'h0001;
					s_next.ovf   = 1'b1;
					ovf_set      = 1'b1;
				end else begin
					s_next.count = s_reg.down ? s_reg.count - 16'h0001
						: s_reg.count + 16'h0001;
				end
			end
			// buffered compare update at top or bottom
			if (pwm && ((upd_bottom && s_reg.down && s_reg.count == timer16_pkg::CNT_BOTTOM)
					|| (!upd_bottom && !s_reg.down && s_reg.count >= top))) begin
				s_next.cmp_a = chan_a_cfg.value;
				s_next.cmp_b = chan_b_cfg.value;
			end
			// setting standing at the match is used, so a new one acts from the
			// first match after it is written, never at the write itself
			if (s_reg.count == s_reg.cmp_a) begin
				s_next.act_a = chan_a_cfg.action;
				if (!pwm)
					s_next.pin_a = act_pin(chan_a_cfg.action, s_reg.pin_a);
				else if (waveform_select == timer16_pkg::WAVE_PFC_A
						&& chan_a_cfg.action == timer16_pkg::ACT_TOGGLE)
					s_next.pin_a = ~s_reg.pin_a;
				else
					s_next.pin_a = pwm_pin(chan_a_cfg.action, s_reg.pin_a, s_reg.down,
						s_reg.cmp_a, top);
			end
			if (s_reg.count == s_reg.cmp_b) begin
				s_next.act_b = chan_b_cfg.action;
				if (!pwm)
					s_next.pin_b = act_pin(chan_b_cfg.action, s_reg.pin_b);
				else
					s_next.pin_b = pwm_pin(chan_b_cfg.action, s_reg.pin_b, s_reg.down,
						s_reg.cmp_b, top);
			end
		end
		// unbuffered modes follow the written compare directly
		if (!buffered) begin
			s_next.cmp_a = chan_a_cfg.value;
			s_next.cmp_b = chan_b_cfg.value;
		end
		// forced match: immediate, no flag, no clear
		if (!pwm && chan_a_cfg.force_strobe) begin
			s_next.pin_a = act_pin(chan_a_cfg.action, s_reg.pin_a);
			s_next.act_a = chan_a_cfg.action;
		end
		if (!pwm && chan_b_cfg.force_strobe) begin
			s_next.pin_b = act_pin(chan_b_cfg.action, s_reg.pin_b);
			s_next.act_b = chan_b_cfg.action;
		end
		// software write of the counter wins over counting
		if (counter_write)
			s_next.count = counter_wdata;
		// overflow clear loses to a same-cycle set
		if (overflow_ack && !ovf_set)
			s_next.ovf = 1'b0;
	end

	// single state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg       <= '0;
			s_reg.count <= timer16_pkg::CNT_RESET;
			s_reg.cmp_a <= timer16_pkg::CMP_RESET;
			s_reg.cmp_b <= timer16_pkg::CMP_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign counter_value        = s_reg.count;
	assign overflow_flag        = s_reg.ovf;
	assign compare_flag_a       = s_reg.flag_a;
	assign compare_flag_b       = s_reg.flag_b;
	assign channel_a_output_pin = s_reg.pin_a;
	assign compare_output_pin_b = s_reg.pin_b;

	a_normal_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && waveform_select == timer16_pkg::WAVE_NORMAL && !counter_write
		&& s_reg.count == timer16_pkg::CNT_MAX) |=> (counter_value == 16'h0000 && overflow_flag))
		else $error("normal mode wrap or overflow wrong");
	a_ovf_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(overflow_flag && !overflow_ack) |=> overflow_flag)
		else $error("overflow flag lost");
	a_match_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && waveform_select == timer16_pkg::WAVE_CLR_A && !counter_write
		&& s_reg.count == s_reg.cmp_a) |=> counter_value == 16'h0000)
		else $error("clear on match did not clear");
	a_flag_a_set: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && s_reg.count == s_reg.cmp_a) |=> compare_flag_a)
		else $error("compare flag a not set");
	a_action_none: assert property (@(posedge clk) disable iff (!rst_n)
		(!pwm && chan_a_cfg.action == timer16_pkg::ACT_NONE && !chan_a_cfg.force_strobe)
		|=> $stable(channel_a_output_pin))
		else $error("pin a moved with no action");
	a_force_set: assert property (@(posedge clk) disable iff (!rst_n)
		(!pwm && chan_a_cfg.force_strobe && chan_a_cfg.action == timer16_pkg::ACT_SET)
		|=> channel_a_output_pin)
		else $error("force did not set pin a");
	a_cnt_write: assert property (@(posedge clk) disable iff (!rst_n)
		counter_write |=> counter_value == $past(counter_wdata))
		else $error("counter write lost");
	a_normal_up: assert property (@(posedge clk) disable iff (!rst_n)
		(tick && waveform_select == timer16_pkg::WAVE_NORMAL && !counter_write)
		|=> counter_value == $past(s_reg.count) + 16'h0001)
		else $error("normal mode did not increment");
	c_ovf: cover property (@(posedge clk) disable iff (!rst_n) $rose(overflow_flag));
	c_clear_match: cover property (@(posedge clk) disable iff (!rst_n)
		waveform_select == timer16_pkg::WAVE_CLR_A && $rose(compare_flag_a));
	c_pwm_down: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_reg.down));
	c_match_b: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_reg.match_b));
endmodule

// >>> tb/sixteen_bit_timer_waveform_bench.sv
`timescale 1ns/100ps
module sixteen_bit_timer_waveform_bench;
	logic                      clk;
	logic                      rst_n;
	logic                      timer_tick;
	logic [3:0]                waveform_select;
	timer16_pkg::channel_cfg_t chan_a_cfg;
	timer16_pkg::channel_cfg_t chan_b_cfg;
	logic [15:0]               capture_value;
	logic                      counter_write;
	logic [15:0]               counter_wdata;
	logic                      overflow_ack;
	logic                      flag_a_ack;
	logic                      flag_b_ack;
	logic [15:0]               counter_value;
	logic                      overflow_flag;
	logic                      compare_flag_a;
	logic                      compare_flag_b;
	logic                      pin_a;
	logic                      pin_b;
	int                        err_total;
	int                        check_count;
	int                        seed;
	logic [15:0]               v;
	logic                      ep;
	logic [1:0]                acts [6];

	timer16 dut (
		.clk                  (clk),
		.rst_n                (rst_n),
		.timer_tick           (timer_tick),
		.waveform_select      (waveform_select),
		.chan_a_cfg           (chan_a_cfg),
		.chan_b_cfg           (chan_b_cfg),
		.capture_value        (capture_value),
		.counter_write        (counter_write),
		.counter_wdata        (counter_wdata),
		.overflow_ack         (overflow_ack),
		.flag_a_ack           (flag_a_ack),
		.flag_b_ack           (flag_b_ack),
		.counter_value        (counter_value),
		.overflow_flag        (overflow_flag),
		.compare_flag_a       (compare_flag_a),
		.compare_flag_b       (compare_flag_b),
		.channel_a_output_pin (pin_a),
		.compare_output_pin_b (pin_b)
	);

	// 25 mhz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// tick held 3 clocks high and 3 low so the synchroniser sees every one
	task automatic ticks(input int n);
		repeat (n) begin
			@(negedge clk) timer_tick = 1'b1;
			repeat (3) @(negedge clk);
			timer_tick = 1'b0;
			repeat (3) @(negedge clk);
		end
	endtask

	task automatic wr(input logic [15:0] d);
		@(negedge clk);
		counter_write = 1'b1;
		counter_wdata = d;
		@(negedge clk);
		counter_write = 1'b0;
	endtask

	// action set a cycle ahead so the strobe never races the field
	task automatic force_ch(input int ch, input logic [1:0] act);
		@(negedge clk);
		if (ch == 0) chan_a_cfg.action = act;
		else chan_b_cfg.action = act;
		@(negedge clk);
		if (ch == 0) chan_a_cfg.force_strobe = 1'b1;
		else chan_b_cfg.force_strobe = 1'b1;
		@(negedge clk);
		chan_a_cfg.force_strobe = 1'b0;
		chan_b_cfg.force_strobe = 1'b0;
		@(negedge clk);
	endtask

	task automatic ack_all();
		@(negedge clk);
		{overflow_ack, flag_a_ack, flag_b_ack} = 3'h7;
		@(negedge clk);
		{overflow_ack, flag_a_ack, flag_b_ack} = 3'h0;
		@(negedge clk);
	endtask

	function automatic logic pin_after(input logic [1:0] act, input logic cur);
		case (act)
			timer16_pkg::ACT_SET:    return 1'b1;
			timer16_pkg::ACT_CLEAR:  return 1'b0;
			timer16_pkg::ACT_TOGGLE: return ~cur;
			default:                 return cur;
		endcase
	endfunction

	// watchdog, far beyond the few dozen ticks of the run
	initial begin
		#400000;
		err_total++;
		end_sim();
	end

	initial begin
		{rst_n, timer_tick, counter_write, overflow_ack, flag_a_ack, flag_b_ack} = 6'h00;
		{err_total, check_count, seed} = {32'h0, 32'h0, 32'h564f_723e};
		waveform_select = timer16_pkg::WAVE_NORMAL;
		chan_a_cfg = '0;
		chan_b_cfg = '0;
		capture_value = 16'h0000;
		counter_wdata = 16'h0000;
		acts = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3};
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk("counter", timer16_pkg::CNT_RESET, counter_value);
		// forced actions on both channels, none keeps the pin
		for (int ch = 0; ch < 2; ch++) begin
			ep = 1'b0;
			foreach (acts[i]) begin
				force_ch(ch, acts[i]);
				ep = pin_after(acts[i], ep);
				chk("pin", {15'h0, ep}, {15'h0, ch == 0 ? pin_a : pin_b});
			end
		end
		// strobe refused in a pwm mode
		chan_a_cfg.value = 16'h0080;
		waveform_select = timer16_pkg::WAVE_PC8;
		force_ch(0, timer16_pkg::ACT_CLEAR);
		chk("pin_a pwm", 16'h0001, {15'h0, pin_a});
		waveform_select = timer16_pkg::WAVE_NORMAL;
		chan_a_cfg.action = timer16_pkg::ACT_NONE;
		chan_b_cfg.action = timer16_pkg::ACT_NONE;
		repeat (4) begin
			v = 16'($random(seed));
			wr(v);
			chk("counter write", v, counter_value);
		end
		// wrap past max and overflow flag
		wr(16'hFFFE);
		ticks(1);
		chk("counter", 16'hFFFF, counter_value);
		chk("overflow", 16'h0000, {15'h0, overflow_flag});
		ticks(1);
		chk("counter", 16'h0000, counter_value);
		chk("overflow", 16'h0001, {15'h0, overflow_flag});
		ticks(1);
		chk("overflow held", 16'h0001, {15'h0, overflow_flag});
		ack_all();
		chk("overflow ack", 16'h0000, {15'h0, overflow_flag});
		// compare flags one tick after the match, no clear in normal mode
		v = (16'($random(seed)) & 16'h7FFF) | 16'h0010;
		chan_a_cfg.value = v;
		chan_b_cfg.value = v + 16'h0002;
		chan_a_cfg.action = timer16_pkg::ACT_TOGGLE;
		wr(v - 16'h0001);
		ticks(2);
		chk("counter past match", v + 16'h0001, counter_value);
		chk("flag a", 16'h0001, {15'h0, compare_flag_a});
		chk("flag b", 16'h0000, {15'h0, compare_flag_b});
		chk("pin_a at match", 16'h0000, {15'h0, pin_a});
		ticks(2);
		chk("flag b", 16'h0001, {15'h0, compare_flag_b});
		chk("pin_b no action", 16'h0001, {15'h0, pin_b});
		ack_all();
		chk("flag a ack", 16'h0000, {15'h0, compare_flag_a});
		// clear on match, top from compare a then from capture
		for (int m = 0; m < 2; m++) begin
			v = 16'h0002 + {14'h0, 2'($random(seed))};
			waveform_select = m == 0 ? timer16_pkg::WAVE_CLR_A : timer16_pkg::WAVE_CLR_I;
			chan_a_cfg.value = m == 0 ? v : 16'h7000;
			chan_a_cfg.action = m == 0 ? timer16_pkg::ACT_NONE : timer16_pkg::ACT_TOGGLE;
			capture_value = v;
			wr(16'h0000);
			ticks(int'(v));
			chk("counter at top", v, counter_value);
			ticks(1);
			chk("counter cleared", 16'h0000, counter_value);
		end
		// phase-correct 8-bit, compare at bottom: a inverted, b non-inverted
		waveform_select = timer16_pkg::WAVE_PC8;
		chan_a_cfg.value = 16'h0000;
		chan_a_cfg.action = timer16_pkg::ACT_SET;
		chan_b_cfg.value = 16'h0000;
		chan_b_cfg.action = timer16_pkg::ACT_CLEAR;
		wr(16'h00FE);
		ticks(2); // turns at top, buffers load there
		wr(16'h0001);
		ticks(2);
		chk("pc counter", 16'h0001, counter_value);
		chk("pin_a inverted", 16'h0001, {15'h0, pin_a});
		chk("pin_b non-inverted", 16'h0000, {15'h0, pin_b});
		// compare a as top with toggle: one toggle per period, half duty
		waveform_select = timer16_pkg::WAVE_PFC_A;
		chan_a_cfg.value = 16'h0003;
		chan_a_cfg.action = timer16_pkg::ACT_TOGGLE;
		ticks(1);
		wr(16'h0000);
		ticks(1); // bottom: top of 3 loaded from the buffer
		ep = pin_a;
		ticks(3);
		chk("pin_a toggled", {15'h0, ~ep}, {15'h0, pin_a});
		ticks(3);
		chk("pin_a half period", {15'h0, ~ep}, {15'h0, pin_a});
		ticks(3);
		chk("pin_a full period", {15'h0, ep}, {15'h0, pin_a});
		end_sim();
	end
endmodule
